// ==== common/piofce_pkg.sv ====
// Shared constants for the port function command engine
package piofce_pkg;
  // Function and ROM command codes
  localparam logic [7:0] SKIP_ROM_CODE = 8'hCC;
  localparam logic [7:0] REGISTER_READ_CMD = 8'hF0;
  localparam logic [7:0] SEARCH_WRITE_CMD = 8'hCC;
  localparam logic [7:0] CHANNEL_READ_CMD = 8'hF5;
  localparam logic [7:0] CHANNEL_WRITE_CMD = 8'h5A;
  localparam logic [7:0] LATCH_CLEAR_CMD = 8'hC3;
  // Answer bytes
  localparam logic [7:0] FILL_BYTE = 8'hFF;
  localparam logic [7:0] CONFIRM_BYTE = 8'hAA;
  // Register page addresses, low byte; high byte must be zero
  localparam logic [7:0] TARGET_HIGH_VALID = 8'h00;
  localparam logic [7:0] PIN_STATE_ADDR = 8'h88;
  localparam logic [7:0] OUT_LATCH_ADDR = 8'h89;
  localparam logic [7:0] ACTIVITY_ADDR = 8'h8A;
  localparam logic [7:0] SEL_MASK_ADDR = 8'h8B;
  localparam logic [7:0] POLARITY_ADDR = 8'h8C;
  localparam logic [7:0] CONTROL_STATUS_ADDR = 8'h8D;
  localparam logic [7:0] PAGE_LAST_ADDR = 8'h8F;
  // Control/status field positions
  localparam int CS_ROS_BIT = 2;
  localparam int CS_PORL_BIT = 3;
  localparam int CS_VCC_BIT = 7;
  // Values after reset
  localparam logic [7:0] OUT_LATCH_RESET = 8'hFF;
  localparam logic [7:0] SEL_MASK_RESET = 8'h00;
  localparam logic [7:0] POLARITY_RESET = 8'h00;
  localparam logic [3:0] CONTROL_RESET = 4'h8;
  localparam logic [15:0] CRC_RESET = 16'h0000;
  // Reflected form of x16+x15+x2+1, bits shifted in LSB first
  localparam logic [15:0] CRC_POLY_REFLECTED = 16'hA001;
  // Samples per channel read block
  localparam int SAMPLES_PER_BLOCK = 32;
  // Depth of the receive byte queue
  localparam int RX_QUEUE_DEPTH = 4;
  // Engine states, one-hot
  typedef enum logic [13:0] {
    S_ROM = 14'h0001,
    S_CMD = 14'h0002,
    S_ALO = 14'h0004,
    S_AHI = 14'h0008,
    S_RDD = 14'h0010,
    S_RCRC = 14'h0020,
    S_WCS = 14'h0040,
    S_CHR = 14'h0080,
    S_CCRC = 14'h0100,
    S_CW1 = 14'h0200,
    S_CW2 = 14'h0400,
    S_ACK = 14'h0800,
    S_AA = 14'h1000,
    S_FF = 14'h2000
  } piofce_state_e;
endpackage : piofce_pkg

// ==== hdl/piofce_fifo.sv ====
// Small flip-flop FIFO with valid/ready on both sides
`timescale 1ns/10ps
module piofce_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  input wire logic flush,
  // Filling side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // Draining side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0] cnt_q, cnt_d;
  logic rdy_q, rdy_d;
  logic push, pop;

  assign push = in_valid & rdy_q;
  assign pop = out_valid & out_ready;
  assign in_ready = rdy_q;
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];

  // Pointer and count update; flush drops everything queued
  always_comb begin
    wr_d = wr_q;
    rd_d = rd_q;
    cnt_d = cnt_q;
    if (push) begin
      wr_d = (wr_q == LAST) ? '0 : wr_q + 1'b1;
    end
    if (pop) begin
      rd_d = (rd_q == LAST) ? '0 : rd_q + 1'b1;
    end
    cnt_d = cnt_q + (push ? 1'b1 : 1'b0) - (pop ? 1'b1 : 1'b0);
    if (flush) begin
      wr_d = '0;
      rd_d = '0;
      cnt_d = '0;
    end
    rdy_d = (cnt_d != FULL);
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      rdy_q <= 1'b0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
      rdy_q <= rdy_d;
    end
  end

  // Storage, one entry per word
  for (genvar i = 0; i < DEPTH; i++) begin : g_mem
    always_ff @(posedge clock) begin
      if (push && wr_q == AW'(i)) begin
        mem_q[i] <= in_data;
      end
    end
  end
endmodule : piofce_fifo

// ==== hdl/piofce_engine.sv ====
// Function command engine of an eight-channel open-drain port expander
// Functional notes
// - Skip-ROM CCh precedes commands; bytes LSB first
// - Register read F0h, then address low, high
// - Valid read: data, inverted CRC, then FFh
// - Invalid read address: only FFh until reset
// - Search write CCh, address, data bytes stored
// - After search write: no CRC, reads FFh
// - Invalid search write address: no data, FFh
// - Channel read: endless 32 samples plus CRC
// - Pins sampled right before each channel byte
// - Outputs change on exact complement pair, or reset pin low in reset mode
// - Accepted pair answers AAh then pin sample
// - Write pairs repeat until bus reset
// - Bad pair: outputs kept, loop ends, FFh
// - Latch clear command always carried out
// - CRC16 x16+x15+x2+1, cleared start, inverted
// - Read CRC spans command, address, data to 8Fh
// - First channel CRC has command; later only samples
`timescale 1ns/10ps
module piofce_engine #(
  parameter int RX_DEPTH = piofce_pkg::RX_QUEUE_DEPTH,
  parameter logic VCC_PRESENT = 1'b1
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Bytes received from the bus, LSB already first in bit 0
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  output logic rx_ready,
  // Read slot byte requests and answers
  input wire logic tx_req,
  output logic tx_valid,
  output logic [7:0] tx_byte,
  // Bus reset seen by the slot layer
  input wire logic bus_reset,
  // Open-drain port pins
  input wire logic [7:0] pio_in,
  output logic [7:0] pio_out,
  output logic [7:0] pio_oe,
  // Reset input or strobe output pin
  input wire logic reset_or_strobe_pin_in,
  output logic reset_or_strobe_pin_out,
  output logic reset_or_strobe_pin_oe
);
  localparam logic [4:0] LAST_SAMPLE = 5'(piofce_pkg::SAMPLES_PER_BLOCK - 1);

  piofce_pkg::piofce_state_e state_q, state_d;
  logic [7:0] addr_q, addr_d;
  logic [7:0] first_q, first_d;
  logic [15:0] crc_q, crc_d;
  logic [4:0] cnt_q, cnt_d;
  logic hi_q, hi_d;
  logic search_q, search_d;
  logic [7:0] latch_q, latch_d;
  logic [7:0] act_q, act_d;
  logic [7:0] mask_q, mask_d;
  logic [7:0] pol_q, pol_d;
  logic [3:0] ctl_q, ctl_d;
  logic tx_valid_q, tx_valid_d;
  logic [7:0] tx_byte_q, tx_byte_d;
  logic [7:0] oe_q, oe_d;
  logic data_valid_pulse_out_q, data_valid_pulse_out_d;
  logic [7:0] pin_meta_q, pin_q, pin_prev_q;
  logic rs_meta_q, rs_q;
  logic q_valid, q_pop, take;
  logic [7:0] q_byte;

  // Receive queue lets the engine stall the slot layer while it answers
  piofce_fifo #(
    .WIDTH(8),
    .DEPTH(RX_DEPTH)
  ) u_rx_queue (
    .clock(clock),
    .rst_n(rst_n),
    .flush(bus_reset),
    .in_valid(rx_valid),
    .in_data(rx_byte),
    .in_ready(rx_ready),
    .out_valid(q_valid),
    .out_data(q_byte),
    .out_ready(q_pop)
  );

  // One CRC16 step per byte, bit 0 first
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      if (r[0] ^ b[i]) begin
        r = (r >> 1) ^ piofce_pkg::CRC_POLY_REFLECTED;
      end else begin
        r = r >> 1;
      end
    end
    return r;
  endfunction : crc_step

  // Register page contents as seen by a register read
  function automatic logic [7:0] page_byte(input logic [7:0] a);
    logic [7:0] v;
    v = piofce_pkg::FILL_BYTE;
    case (a)
      piofce_pkg::PIN_STATE_ADDR: v = pin_q;
      piofce_pkg::OUT_LATCH_ADDR: v = latch_q;
      piofce_pkg::ACTIVITY_ADDR: v = act_q;
      piofce_pkg::SEL_MASK_ADDR: v = mask_q;
      piofce_pkg::POLARITY_ADDR: v = pol_q;
      piofce_pkg::CONTROL_STATUS_ADDR: begin
        v = {4'h0, ctl_q};
        v[piofce_pkg::CS_VCC_BIT] = VCC_PRESENT;
      end
      default: v = piofce_pkg::FILL_BYTE;
    endcase
    return v;
  endfunction : page_byte

  // Bytes are held while answering data, CRC, samples or a write pair; every other state drains them
  always_comb begin
    case (state_q)
      piofce_pkg::S_RDD, piofce_pkg::S_RCRC, piofce_pkg::S_CHR,
      piofce_pkg::S_CCRC, piofce_pkg::S_ACK: take = 1'b0;
      default: take = 1'b1;
    endcase
  end
  // A bus reset drops the head byte rather than letting it touch any register
  assign q_pop = q_valid & take & ~bus_reset;

  // Command sequencing, answers and register updates
  always_comb begin
    state_d = state_q;
    addr_d = addr_q;
    first_d = first_q;
    crc_d = crc_q;
    cnt_d = cnt_q;
    hi_d = hi_q;
    search_d = search_q;
    latch_d = latch_q;
    mask_d = mask_q;
    pol_d = pol_q;
    ctl_d = ctl_q;
    data_valid_pulse_out_d = 1'b0;
    tx_valid_d = tx_req;
    // The answer byte stands until the next read slot replaces it
    tx_byte_d = tx_req ? piofce_pkg::FILL_BYTE : tx_byte_q;
    // Activity latches: a change seen in the same cycle as a clear still sets
    act_d = act_q;
    case (state_q)
      piofce_pkg::S_ROM: begin
        if (q_pop) begin
          // Any other ROM byte leaves the device silent until bus reset
          state_d = (q_byte == piofce_pkg::SKIP_ROM_CODE) ? piofce_pkg::S_CMD
                                                           : piofce_pkg::S_FF;
        end
      end
      piofce_pkg::S_CMD: begin
        if (q_pop) begin
          crc_d = crc_step(piofce_pkg::CRC_RESET, q_byte);
          cnt_d = '0;
          hi_d = 1'b0;
          case (q_byte)
            piofce_pkg::REGISTER_READ_CMD: begin
              search_d = 1'b0;
              state_d = piofce_pkg::S_ALO;
            end
            piofce_pkg::SEARCH_WRITE_CMD: begin
              search_d = 1'b1;
              state_d = piofce_pkg::S_ALO;
            end
            piofce_pkg::CHANNEL_READ_CMD: state_d = piofce_pkg::S_CHR;
            piofce_pkg::CHANNEL_WRITE_CMD: state_d = piofce_pkg::S_CW1;
            piofce_pkg::LATCH_CLEAR_CMD: begin
              act_d = '0;
              state_d = piofce_pkg::S_AA;
            end
            default: state_d = piofce_pkg::S_FF;
          endcase
        end
      end
      piofce_pkg::S_ALO: begin
        if (q_pop) begin
          addr_d = q_byte;
          crc_d = crc_step(crc_q, q_byte);
          state_d = piofce_pkg::S_AHI;
        end
      end
      piofce_pkg::S_AHI: begin
        if (q_pop) begin
          crc_d = crc_step(crc_q, q_byte);
          state_d = piofce_pkg::S_FF;
          if (q_byte == piofce_pkg::TARGET_HIGH_VALID) begin
            if (!search_q && addr_q >= piofce_pkg::PIN_STATE_ADDR &&
                addr_q <= piofce_pkg::PAGE_LAST_ADDR) begin
              state_d = piofce_pkg::S_RDD;
            end
            if (search_q && addr_q >= piofce_pkg::SEL_MASK_ADDR &&
                addr_q <= piofce_pkg::CONTROL_STATUS_ADDR) begin
              state_d = piofce_pkg::S_WCS;
            end
          end
        end
      end
      piofce_pkg::S_RDD: begin
        if (tx_req) begin
          tx_byte_d = page_byte(addr_q);
          crc_d = crc_step(crc_q, page_byte(addr_q));
          if (addr_q == piofce_pkg::PAGE_LAST_ADDR) begin
            state_d = piofce_pkg::S_RCRC;
          end else begin
            addr_d = addr_q + 8'h01;
          end
        end
      end
      piofce_pkg::S_RCRC: begin
        if (tx_req) begin
          tx_byte_d = hi_q ? ~crc_q[15:8] : ~crc_q[7:0];
          hi_d = ~hi_q;
          if (hi_q) begin
            state_d = piofce_pkg::S_FF;
          end
        end
      end
      piofce_pkg::S_WCS: begin
        // Bytes past the control register are dropped; reads answer FFh
        if (q_pop) begin
          case (addr_q)
            piofce_pkg::SEL_MASK_ADDR: mask_d = q_byte;
            piofce_pkg::POLARITY_ADDR: pol_d = q_byte;
            piofce_pkg::CONTROL_STATUS_ADDR: begin
              ctl_d[2:0] = q_byte[2:0];
              // The power-on latch can only be cleared by software
              ctl_d[piofce_pkg::CS_PORL_BIT] = ctl_q[piofce_pkg::CS_PORL_BIT] &
                                               q_byte[piofce_pkg::CS_PORL_BIT];
            end
            default: ;
          endcase
          if (addr_q <= piofce_pkg::CONTROL_STATUS_ADDR) begin
            addr_d = addr_q + 8'h01;
          end
        end
      end
      piofce_pkg::S_CHR: begin
        if (tx_req) begin
          tx_byte_d = pin_q;
          crc_d = crc_step(crc_q, pin_q);
          data_valid_pulse_out_d = 1'b1;
          cnt_d = cnt_q + 5'h01;
          if (cnt_q == LAST_SAMPLE) begin
            state_d = piofce_pkg::S_CCRC;
          end
        end
      end
      piofce_pkg::S_CCRC: begin
        if (tx_req) begin
          tx_byte_d = hi_q ? ~crc_q[15:8] : ~crc_q[7:0];
          hi_d = ~hi_q;
          if (hi_q) begin
            crc_d = piofce_pkg::CRC_RESET;
            cnt_d = '0;
            state_d = piofce_pkg::S_CHR;
          end
        end
      end
      piofce_pkg::S_CW1: begin
        if (q_pop) begin
          first_d = q_byte;
          state_d = piofce_pkg::S_CW2;
        end
      end
      piofce_pkg::S_CW2: begin
        if (q_pop) begin
          if (q_byte == ~first_q) begin
            latch_d = first_q;
            data_valid_pulse_out_d = 1'b1;
            hi_d = 1'b0;
            state_d = piofce_pkg::S_ACK;
          end else begin
            state_d = piofce_pkg::S_FF;
          end
        end
      end
      piofce_pkg::S_ACK: begin
        if (tx_req) begin
          hi_d = ~hi_q;
          tx_byte_d = hi_q ? pin_q : piofce_pkg::CONFIRM_BYTE;
          if (hi_q) begin
            state_d = piofce_pkg::S_CW1;
          end
        end
      end
      piofce_pkg::S_AA: begin
        if (tx_req) begin
          tx_byte_d = piofce_pkg::CONFIRM_BYTE;
        end
      end
      piofce_pkg::S_FF: ;
      default: state_d = piofce_pkg::S_FF;
    endcase
    act_d = act_d | (pin_q ^ pin_prev_q);
    // Reset input mode: a low pin switches every output off
    if (!ctl_q[piofce_pkg::CS_ROS_BIT] && !rs_q) begin
      latch_d = piofce_pkg::OUT_LATCH_RESET;
    end
    // Strobe only in strobe mode; folded in here so the pin comes from one flop
    data_valid_pulse_out_d = data_valid_pulse_out_d & ctl_q[piofce_pkg::CS_ROS_BIT];
    if (bus_reset) begin
      state_d = piofce_pkg::S_ROM;
      tx_valid_d = 1'b0;
      tx_byte_d = tx_byte_q;
      data_valid_pulse_out_d = 1'b0;
    end
    oe_d = ~latch_d;
  end

  // Engine state registers
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_q <= piofce_pkg::S_ROM;
      addr_q <= 8'h00;
      first_q <= 8'h00;
      crc_q <= piofce_pkg::CRC_RESET;
      cnt_q <= 5'h00;
      hi_q <= 1'b0;
      search_q <= 1'b0;
      latch_q <= piofce_pkg::OUT_LATCH_RESET;
      act_q <= 8'h00;
      mask_q <= piofce_pkg::SEL_MASK_RESET;
      pol_q <= piofce_pkg::POLARITY_RESET;
      ctl_q <= piofce_pkg::CONTROL_RESET;
      tx_valid_q <= 1'b0;
      tx_byte_q <= piofce_pkg::FILL_BYTE;
      oe_q <= 8'h00;
      data_valid_pulse_out_q <= 1'b0;
    end else begin
      state_q <= state_d;
      addr_q <= addr_d;
      first_q <= first_d;
      crc_q <= crc_d;
      cnt_q <= cnt_d;
      hi_q <= hi_d;
      search_q <= search_d;
      latch_q <= latch_d;
      act_q <= act_d;
      mask_q <= mask_d;
      pol_q <= pol_d;
      ctl_q <= ctl_d;
      tx_valid_q <= tx_valid_d;
      tx_byte_q <= tx_byte_d;
      oe_q <= oe_d;
      data_valid_pulse_out_q <= data_valid_pulse_out_d;
    end
  end

  // Pin synchronisers; the previous sample feeds the activity latches
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pin_meta_q <= 8'hFF;
      pin_q <= 8'hFF;
      pin_prev_q <= 8'hFF;
      rs_meta_q <= 1'b1;
      rs_q <= 1'b1;
    end else begin
      pin_meta_q <= pio_in;
      pin_q <= pin_meta_q;
      pin_prev_q <= pin_q;
      rs_meta_q <= reset_or_strobe_pin_in;
      rs_q <= rs_meta_q;
    end
  end

  // Open-drain drive: only ever pulls low
  assign pio_out = 8'h00;
  assign pio_oe = oe_q;
  assign reset_or_strobe_pin_out = 1'b0;
  assign reset_or_strobe_pin_oe = data_valid_pulse_out_q;
  assign tx_valid = tx_valid_q;
  assign tx_byte = tx_byte_q;
endmodule : piofce_engine

// ==== bench/piofce_engine_asserts.sv ====
// Checker for the port function command engine
`timescale 1ns/10ps
module piofce_engine_asserts (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Byte link
  input wire logic rx_valid,
  input wire logic rx_ready,
  input wire logic tx_req,
  input wire logic tx_valid,
  input wire logic [7:0] tx_byte,
  input wire logic bus_reset,
  // Pins
  input wire logic [7:0] pio_out,
  input wire logic [7:0] pio_oe,
  input wire logic reset_or_strobe_pin_out
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Bus reset followed at once by a lone read slot
  sequence seq_fresh;
    bus_reset && !rx_valid ##1 tx_req && !bus_reset && !rx_valid;
  endsequence
  // First edge after the engine leaves reset
  sequence seq_release;
    $rose(rst_n);
  endsequence
  chk_tx_answer: assert property (tx_req && !bus_reset |=> tx_valid)
    else $error("read slot got no answer");
  chk_tx_silent: assert property (!tx_req |=> !tx_valid)
    else $error("answer without a read slot");
  chk_tx_hold: assert property (!tx_valid |-> $stable(tx_byte))
    else $error("answer byte moved between answers");
  chk_bus_fill: assert property (seq_fresh |=> tx_valid && tx_byte == 8'hFF)
    else $error("no fill byte after bus reset");
  chk_pins_low: assert property (pio_out == 8'h00 && !reset_or_strobe_pin_out)
    else $error("open drain pin driven high");
  chk_ready_release: assert property (seq_release |=> rx_ready)
    else $error("queue not ready after reset");
  chk_oe_release: assert property (seq_release |-> pio_oe == 8'h00)
    else $error("outputs pulled low out of reset");
  chk_flush_ready: assert property (bus_reset |-> ##[1:3] rx_ready)
    else $error("queue not flushed by bus reset");
endmodule : piofce_engine_asserts

bind piofce_engine piofce_engine_asserts u_chk (.clock, .rst_n, .rx_valid, .rx_ready,
  .tx_req, .tx_valid, .tx_byte, .bus_reset, .pio_out, .pio_oe, .reset_or_strobe_pin_out);

// ==== bench/piofce_master_model.sv ====
// Byte level model of the bus master facing the engine
`timescale 1ns/10ps
module piofce_master_model (
  // Clock
  input wire logic clock,
  // Byte link toward the engine
  output logic rx_valid,
  output logic [7:0] rx_byte,
  input wire logic rx_ready,
  output logic tx_req,
  input wire logic tx_valid,
  input wire logic [7:0] tx_byte,
  output logic bus_reset,
  // Set when rx_ready stayed low for 40 clock edges after a byte was offered
  output logic hung
);
  // Idle link at time zero
  initial begin
    rx_valid = 1'b0;
    rx_byte = 8'h00;
    tx_req = 1'b0;
    bus_reset = 1'b0;
    hung = 1'b0;
  end
  // Offer a byte and hold it until rx_ready is seen high after a clock edge; released data is inverted so it is never reused
  task automatic put_byte(input logic [7:0] b);
    int n = 0;
    @(negedge clock);
    rx_valid = 1'b1;
    rx_byte = b;
    do begin
      @(posedge clock);
      n++;
    end while (rx_ready !== 1'b1 && n < 40);
    if (rx_ready !== 1'b1) hung = 1'b1;
    @(negedge clock);
    rx_valid = 1'b0;
    rx_byte = ~b;
  endtask : put_byte
  // Read slot; idle gap lets earlier bytes drain out of the queue first
  task automatic get_byte(output logic [7:0] b);
    repeat (3) @(negedge clock);
    tx_req = 1'b1;
    @(negedge clock);
    tx_req = 1'b0;
    b = (tx_valid === 1'b1) ? tx_byte : 8'hXX;
  endtask : get_byte
  // Bus reset pulse, then an immediate read slot
  task automatic bus_rst(output logic [7:0] b);
    @(negedge clock);
    bus_reset = 1'b1;
    @(negedge clock);
    bus_reset = 1'b0;
    tx_req = 1'b1;
    @(negedge clock);
    tx_req = 1'b0;
    b = (tx_valid === 1'b1) ? tx_byte : 8'hXX;
  endtask : bus_rst
endmodule : piofce_master_model

// ==== bench/pio_function_command_engine_test.sv ====
// Self-checking bench for the port function command engine
`timescale 1ns/10ps
module pio_function_command_engine_test;
  typedef logic [7:0] piofce_bytes_t[$];
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic rx_valid, rx_ready, tx_req, tx_valid, bus_reset, hung;
  logic [7:0] rx_byte, tx_byte, pio_in, pio_out, pio_oe;
  logic [7:0] ext_pins = 8'hFF;
  logic reset_or_strobe_pin_in, reset_or_strobe_pin_out, reset_or_strobe_pin_oe;
  logic [15:0] crc;
  int err_total = 0;
  int comparisons = 0;
  int strobes = 0;
  int s0;
  // Open-drain pins with pull-ups: low wherever the engine pulls
  assign pio_in = ext_pins & ~pio_oe;
  assign reset_or_strobe_pin_in = ~reset_or_strobe_pin_oe;
  // Clock and strobe pulse counter
  always #5 clock = ~clock;
  always @(posedge clock) if (reset_or_strobe_pin_oe === 1'b1) strobes++;
  piofce_master_model u_master (.clock, .rx_valid, .rx_byte, .rx_ready, .tx_req,
    .tx_valid, .tx_byte, .bus_reset, .hung);
  piofce_engine u_dut (.clock, .rst_n, .rx_valid, .rx_byte, .rx_ready, .tx_req,
    .tx_valid, .tx_byte, .bus_reset, .pio_in, .pio_out, .pio_oe, .reset_or_strobe_pin_in,
    .reset_or_strobe_pin_out, .reset_or_strobe_pin_oe);
  // Reflected CRC16 step, bit 0 first
  function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++) r = (r[0] ^ d[i]) ? ((r >> 1) ^ 16'hA001) : (r >> 1);
    return r;
  endfunction : crc_upd
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : print_verdict
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic send(input piofce_bytes_t q);
    foreach (q[i]) u_master.put_byte(q[i]);
    if (hung === 1'b1) begin
      err_total++;
      print_verdict();
    end
  endtask : send
  task automatic get_chk(input string what, input logic [7:0] exp);
    logic [7:0] b;
    u_master.get_byte(b);
    check(what, b, exp);
  endtask : get_chk
  task automatic bus_rst_chk();
    logic [7:0] b;
    u_master.bus_rst(b);
    check("fill after bus reset", b, 8'hFF);
  endtask : bus_rst_chk
  // Data byte that also feeds the running CRC
  task automatic rd(input logic [7:0] exp);
    get_chk("data", exp);
    crc = crc_upd(crc, exp);
  endtask : rd
  task automatic rd_crc();
    logic [15:0] c;
    c = ~crc;
    get_chk("crc low", c[7:0]);
    get_chk("crc high", c[15:8]);
  endtask : rd_crc
  task automatic reg_read(input logic [7:0] a, input piofce_bytes_t d);
    bus_rst_chk();
    send({8'hCC, 8'hF0, a, 8'h00});
    crc = crc_upd(crc_upd(crc_upd(16'h0000, 8'hF0), a), 8'h00);
    foreach (d[i]) rd(d[i]);
    rd_crc();
    get_chk("fill after crc", 8'hFF);
  endtask : reg_read
  initial begin
    repeat (5) @(negedge clock);
    rst_n = 1'b1;
    // Strobe mode through a search register write, then read the page tail
    bus_rst_chk();
    send({8'hCC, 8'hCC, 8'h8D, 8'h00, 8'h04});
    get_chk("after search write", 8'hFF);
    reg_read(8'h8D, {8'h84, 8'hFF, 8'hFF});
    $display("Test register write and read done");
    // Refused addresses and a foreign ROM byte leave only fill bytes
    bus_rst_chk();
    send({8'hCC, 8'hF0, 8'h90, 8'h00});
    get_chk("bad read address", 8'hFF);
    get_chk("bad read address", 8'hFF);
    bus_rst_chk();
    send({8'hCC, 8'hCC, 8'h80, 8'h00, 8'h55});
    get_chk("bad write address", 8'hFF);
    bus_rst_chk();
    send({8'h33, 8'hF0, 8'h8D, 8'h00});
    get_chk("foreign rom byte", 8'hFF);
    $display("Test refused addresses done");
    // Two good write pairs, then a broken one
    bus_rst_chk();
    s0 = strobes;
    send({8'hCC, 8'h5A, 8'h3C, 8'hC3});
    get_chk("confirm", 8'hAA);
    check("outputs", pio_oe, 8'hC3);
    get_chk("readback", 8'h3C);
    send({8'hA5, 8'h5A});
    get_chk("confirm", 8'hAA);
    get_chk("readback", 8'hA5);
    send({8'h0F, 8'h0F});
    get_chk("after bad pair", 8'hFF);
    get_chk("after bad pair", 8'hFF);
    check("outputs kept", pio_oe, 8'h5A);
    check("write strobes", 8'(strobes - s0), 8'h02);
    $display("Test channel write done");
    // Two sample blocks with changing pins, then fill the stalled queue
    bus_rst_chk();
    send({8'hCC, piofce_pkg::CHANNEL_READ_CMD});
    crc = crc_upd(16'h0000, piofce_pkg::CHANNEL_READ_CMD);
    s0 = strobes;
    for (int k = 0; k < 64; k++) begin
      ext_pins = 8'(k * 37);
      rd(ext_pins & 8'hA5);
      if (k % 32 == 31) begin
        rd_crc();
        crc = 16'h0000;
      end
    end
    check("sample strobes", 8'(strobes - s0), 8'h40);
    send({8'h00, 8'h00, 8'h00, 8'h00});
    check("queue full", {7'h00, rx_ready}, 8'h00);
    bus_rst_chk();
    check("queue flushed", {7'h00, rx_ready}, 8'h01);
    $display("Test channel read done");
    // Burst into the search registers; the byte past control is dropped
    bus_rst_chk();
    send({8'hCC, 8'hCC, 8'h8B, 8'h00, 8'h12, 8'h34, 8'h04, 8'h77});
    get_chk("after burst write", 8'hFF);
    // Every pin bit has toggled by now, so all activity latches are set
    reg_read(8'h8A, {8'hFF, 8'h12, 8'h34, 8'h84, 8'hFF, 8'hFF});
    // Latch clear, then the whole register page
    bus_rst_chk();
    send({8'hCC, piofce_pkg::LATCH_CLEAR_CMD});
    get_chk("clear confirm", 8'hAA);
    reg_read(8'h88, {ext_pins & 8'hA5, 8'hA5, 8'h00, 8'h12, 8'h34, 8'h84, 8'hFF,
      8'hFF});
    $display("Test latch clear done");
    print_verdict();
  end
endmodule : pio_function_command_engine_test
